// ### verilog/dps_ctrl.sv
// Reference switching, loop state, reporting and NCO control
`timescale 1ns/1ps
module dps_ctrl #(
  parameter int GPIO_N = dps_pkg::GPIO_N,
  // Arbitrary neutral nominal word
  parameter logic [dps_pkg::FW-1:0] NCO_NOMINAL = 40'h8000000000
) (
  input wire logic clk,
  input wire logic reset,
  input wire dps_pkg::dps_wb_req_s wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [GPIO_N-1:0] gpio_in,
  input wire dps_pkg::dps_loop_in_s loop_in,
  output dps_pkg::dps_loop_out_s loop_out
);
  localparam int FW = dps_pkg::FW;
  localparam int PW = dps_pkg::NREF * dps_pkg::PRIO_W;
  localparam int SW = $clog2(GPIO_N);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic pin_en;
    logic return_to_higher_en;
    logic [PW-1:0] prio;
    logic [SW-1:0] pin_sel;
    logic [1:0] mode;
    logic ol_sel;
    logic range_limit_flag_lol_en;
    logic [dps_pkg::RANGE_W-1:0] range_ppm;
    logic [1:0] sel_ref;
    logic [1:0] top_ref;
    logic tracking;
    logic loss_of_lock_flag;
    logic keep;
    logic range_limit_flag;
    logic ever_locked;
    logic [dps_pkg::NREF-1:0] lock_timeout_flag;
    logic [dps_pkg::TO_W-1:0] to_limit;
    logic [dps_pkg::TO_W-1:0] to_cnt;
    logic [FW-1:0] freq_rep;
    logic [31:0] phase_rep;
    logic [FW-1:0] nco_word;
    logic [FW-1:0] nco_out;
  } dps_state_s;

  localparam dps_state_s ST_RST = '{
    prio: dps_pkg::PRIO_RST,
    range_ppm: dps_pkg::RANGE_RST,
    to_limit: dps_pkg::TIMEOUT_RST,
    loss_of_lock_flag: 1'b1,
    nco_word: NCO_NOMINAL,
    nco_out: NCO_NOMINAL,
    default: '0
  };

  dps_state_s st_ff;
  dps_state_s nxt_st;
  logic pin_level;
  logic [1:0] pick_top;
  logic pick_any;
  logic [dps_pkg::NREF-1:0] eff_valid;

  function automatic logic [31:0] lanes(input logic [31:0] old,
                                        input logic [31:0] wr,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wr[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [dps_pkg::RANGE_W-1:0] clamp_range(
      input logic [dps_pkg::RANGE_W-1:0] v);
    if (v < dps_pkg::RANGE_MIN) begin
      return dps_pkg::RANGE_MIN;
    end else if (v > dps_pkg::RANGE_MAX) begin
      return dps_pkg::RANGE_MAX;
    end
    return v;
  endfunction

  function automatic logic [dps_pkg::PRIO_W-1:0] prio_of(
      input logic [PW-1:0] p,
      input logic [1:0] idx);
    return p[idx*dps_pkg::PRIO_W +: dps_pkg::PRIO_W];
  endfunction

  dps_pin_sync #(
    .GPIO_N(GPIO_N)
  ) u_pin (
    .clk(clk),
    .reset(reset),
    .gpio_in(gpio_in),
    .switch_pin_sel(st_ff.pin_sel),
    .level(pin_level)
  );

  // Timed-out inputs drop out of automatic selection
  assign eff_valid = loop_in.ref_valid & ~st_ff.lock_timeout_flag;

  dps_ref_pick u_pick (
    .prio(st_ff.prio),
    .valid(eff_valid),
    .top(pick_top),
    .any(pick_any)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic req;
    logic wr;
    logic [31:0] cur;
    logic [31:0] w;
    logic open_loop;
    logic [FW-1:0] abs_f;
    logic [FW-1:0] lim;
    logic [dps_pkg::NREF-1:0] lk_set;
    logic [dps_pkg::NREF-1:0] lk_clr;
    req = 1'b0;
    wr = 1'b0;
    cur = '0;
    w = '0;
    open_loop = 1'b0;
    abs_f = '0;
    lim = '0;
    lk_set = '0;
    lk_clr = '0;
    nxt_st = st_ff;

    // Bus slave: answer one cycle after the request
    req = wb_req.cyc && wb_req.stb && !st_ff.ack;
    wr = req && wb_req.we;
    nxt_st.ack = req;
    case (wb_req.adr)
      dps_pkg::OFF_REF_SEL_CTRL: begin
        cur[dps_pkg::B_PIN_SWITCH_EN] = st_ff.pin_en;
        cur[dps_pkg::B_RETURN_HIGHER] = st_ff.return_to_higher_en;
      end
      dps_pkg::OFF_INPUT_PRIORITY: cur[PW-1:0] = st_ff.prio;
      dps_pkg::OFF_MISC_CTRL_TWO: cur[SW-1:0] = st_ff.pin_sel;
      dps_pkg::OFF_PRIORITY_TABLE_TOP: begin
        cur[dps_pkg::B_SEL_REF +: 2] = st_ff.sel_ref;
        cur[dps_pkg::B_TOP_REF +: 2] = st_ff.top_ref;
      end
      dps_pkg::OFF_LOOP_CTRL: begin
        cur[dps_pkg::B_MODE +: 2] = st_ff.mode;
        cur[dps_pkg::B_OL_SEL] = st_ff.ol_sel;
        cur[dps_pkg::B_RANGE_LIMIT_FLAG_LOL_EN] = st_ff.range_limit_flag_lol_en;
        cur[dps_pkg::B_RANGE +: dps_pkg::RANGE_W] = st_ff.range_ppm;
      end
      dps_pkg::OFF_LOOP_STATE_STATUS: begin
        cur[dps_pkg::B_TRACKING] = st_ff.tracking;
        cur[dps_pkg::B_LOL] = st_ff.loss_of_lock_flag;
        cur[dps_pkg::B_KEEP] = st_ff.keep;
      end
      dps_pkg::OFF_LOOP_STATUS_TWO: cur[dps_pkg::B_RANGE_LIMIT_FLAG] = st_ff.range_limit_flag;
      dps_pkg::OFF_INPUT_STATUS: begin
        cur[dps_pkg::B_LOCK_TIMEOUT_FLAG +: dps_pkg::NREF] = st_ff.lock_timeout_flag;
        cur[dps_pkg::B_VALID +: dps_pkg::NREF] = eff_valid;
      end
      dps_pkg::OFF_LOCK_TIMEOUT: cur[dps_pkg::TO_W-1:0] = st_ff.to_limit;
      dps_pkg::OFF_FREQ_REPORT_LO: cur = st_ff.freq_rep[31:0];
      dps_pkg::OFF_FREQ_REPORT_HI: cur[FW-33:0] = st_ff.freq_rep[FW-1:32];
      dps_pkg::OFF_PHASE_REPORT: cur = st_ff.phase_rep;
      dps_pkg::OFF_NCO_WORD_LO: cur = st_ff.nco_word[31:0];
      dps_pkg::OFF_NCO_WORD_HI: cur[FW-33:0] = st_ff.nco_word[FW-1:32];
      dps_pkg::OFF_NCO_NOMINAL_LO: cur = NCO_NOMINAL[31:0];
      dps_pkg::OFF_NCO_NOMINAL_HI: cur[FW-33:0] = NCO_NOMINAL[FW-1:32];
      default: cur = '0;
    endcase
    nxt_st.rdata = req ? cur : '0;
    w = lanes(cur, wb_req.dat, wb_req.sel);

    if (wr) begin
      case (wb_req.adr)
        dps_pkg::OFF_REF_SEL_CTRL: begin
          nxt_st.pin_en = w[dps_pkg::B_PIN_SWITCH_EN];
          nxt_st.return_to_higher_en = w[dps_pkg::B_RETURN_HIGHER];
        end
        dps_pkg::OFF_INPUT_PRIORITY: nxt_st.prio = w[PW-1:0];
        dps_pkg::OFF_MISC_CTRL_TWO: nxt_st.pin_sel = w[SW-1:0];
        dps_pkg::OFF_LOOP_CTRL: begin
          nxt_st.mode = w[dps_pkg::B_MODE +: 2];
          nxt_st.ol_sel = w[dps_pkg::B_OL_SEL];
          nxt_st.range_limit_flag_lol_en = w[dps_pkg::B_RANGE_LIMIT_FLAG_LOL_EN];
          nxt_st.range_ppm = clamp_range(
              w[dps_pkg::B_RANGE +: dps_pkg::RANGE_W]);
        end
        dps_pkg::OFF_INPUT_STATUS:
          lk_clr = wb_req.dat[dps_pkg::B_LOCK_TIMEOUT_FLAG +: dps_pkg::NREF];
        dps_pkg::OFF_LOCK_TIMEOUT:
          nxt_st.to_limit = w[dps_pkg::TO_W-1:0];
        dps_pkg::OFF_NCO_WORD_LO: nxt_st.nco_word[31:0] = w;
        dps_pkg::OFF_NCO_WORD_HI:
          nxt_st.nco_word[FW-1:32] = w[FW-33:0];
        default: nxt_st.ack = req;
      endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Reference selection
    nxt_st.top_ref = pick_top;
    if (st_ff.pin_en) begin
      if (pin_level) begin
        nxt_st.sel_ref = (prio_of(st_ff.prio, dps_pkg::DPS_REF_A) != '0) ?
                         dps_pkg::DPS_REF_A : dps_pkg::DPS_REF_C;
      end else begin
        nxt_st.sel_ref = dps_pkg::DPS_REF_B;
      end
    end else if (pick_any &&
                 (st_ff.return_to_higher_en || !eff_valid[st_ff.sel_ref] ||
                  prio_of(st_ff.prio, st_ff.sel_ref) == '0)) begin
      nxt_st.sel_ref = pick_top;
    end

    ////////////////////////////////////////////////////////////////////
    // Loop state
    open_loop = (st_ff.mode != dps_pkg::DPS_MODE_AUTO) ||
                !pick_any;
    nxt_st.tracking = !open_loop;
    nxt_st.keep = open_loop && st_ff.ol_sel && st_ff.ever_locked &&
                  (st_ff.mode != dps_pkg::DPS_MODE_NCO);
    if (!st_ff.loss_of_lock_flag && st_ff.tracking) begin
      nxt_st.ever_locked = 1'b1;
    end

    abs_f = loop_in.freq_offset[FW-1] ? FW'(-loop_in.freq_offset) :
            FW'(loop_in.freq_offset);
    lim = FW'({{(FW-dps_pkg::RANGE_W){1'b0}}, st_ff.range_ppm} *
              dps_pkg::FREQ_LSB_PER_PPM);
    nxt_st.range_limit_flag = !open_loop && (abs_f >= lim);
    nxt_st.loss_of_lock_flag = open_loop || !loop_in.phase_locked ||
                 (st_ff.range_limit_flag_lol_en && st_ff.range_limit_flag);

    // Lock timeout counts tracking-but-unlocked cycles
    if (!st_ff.tracking || !st_ff.loss_of_lock_flag || st_ff.to_limit == '0 ||
        nxt_st.sel_ref != st_ff.sel_ref) begin
      nxt_st.to_cnt = '0;
    end else if (st_ff.to_cnt == st_ff.to_limit - 1'b1) begin
      nxt_st.to_cnt = '0;
      lk_set[st_ff.sel_ref] = 1'b1;
    end else begin
      nxt_st.to_cnt = st_ff.to_cnt + 1'b1;
    end
    nxt_st.lock_timeout_flag = (st_ff.lock_timeout_flag & ~lk_clr) | lk_set;

    ////////////////////////////////////////////////////////////////////
    // Reports and oscillator word
    nxt_st.freq_rep = loop_in.freq_offset;
    nxt_st.phase_rep = loop_in.phase;
    if (st_ff.mode == dps_pkg::DPS_MODE_NCO) begin
      nxt_st.nco_out = st_ff.nco_word;
    end else if (nxt_st.keep) begin
      nxt_st.nco_out = st_ff.nco_out;
    end else if (open_loop) begin
      nxt_st.nco_out = NCO_NOMINAL;
    end else begin
      nxt_st.nco_out = st_ff.nco_out;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o = st_ff.rdata;
  assign wb_ack_o = st_ff.ack;
  assign loop_out.selected_ref = st_ff.sel_ref;
  assign loop_out.loop_closed = st_ff.tracking;
  assign loop_out.digital_keep = st_ff.keep;
  assign loop_out.nco_active = (st_ff.mode == dps_pkg::DPS_MODE_NCO);
  assign loop_out.nco_word = st_ff.nco_out;
endmodule

// ### shared/dps_pkg.sv
// Shared constants and carrier types of the reference switch and loop control
package dps_pkg;
  localparam int AW = 8;
  localparam int NREF = 3;
  localparam int PRIO_W = 4;
  localparam int FW = 40;
  localparam int GPIO_N = 4;
  localparam int CLK_HZ = 10_000_000;

  // Register byte offsets
  localparam logic [AW-1:0] OFF_REF_SEL_CTRL = 8'h00;
  localparam logic [AW-1:0] OFF_INPUT_PRIORITY = 8'h04;
  localparam logic [AW-1:0] OFF_MISC_CTRL_TWO = 8'h08;
  localparam logic [AW-1:0] OFF_PRIORITY_TABLE_TOP = 8'h0C;
  localparam logic [AW-1:0] OFF_LOOP_CTRL = 8'h10;
  localparam logic [AW-1:0] OFF_LOOP_STATE_STATUS = 8'h14;
  localparam logic [AW-1:0] OFF_LOOP_STATUS_TWO = 8'h18;
  localparam logic [AW-1:0] OFF_INPUT_STATUS = 8'h1C;
  localparam logic [AW-1:0] OFF_LOCK_TIMEOUT = 8'h20;
  localparam logic [AW-1:0] OFF_FREQ_REPORT_LO = 8'h24;
  localparam logic [AW-1:0] OFF_FREQ_REPORT_HI = 8'h28;
  localparam logic [AW-1:0] OFF_PHASE_REPORT = 8'h2C;
  localparam logic [AW-1:0] OFF_NCO_WORD_LO = 8'h30;
  localparam logic [AW-1:0] OFF_NCO_WORD_HI = 8'h34;
  localparam logic [AW-1:0] OFF_NCO_NOMINAL_LO = 8'h38;
  localparam logic [AW-1:0] OFF_NCO_NOMINAL_HI = 8'h3C;

  // Field positions
  localparam int B_PIN_SWITCH_EN = 0;
  localparam int B_RETURN_HIGHER = 1;
  localparam int B_SEL_REF = 0;
  localparam int B_TOP_REF = 4;
  localparam int B_MODE = 0;
  localparam int B_OL_SEL = 4;
  localparam int B_RANGE_LIMIT_FLAG_LOL_EN = 5;
  localparam int B_RANGE = 16;
  localparam int RANGE_W = 10;
  localparam int B_TRACKING = 0;
  localparam int B_LOL = 1;
  localparam int B_KEEP = 2;
  localparam int B_RANGE_LIMIT_FLAG = 0;
  localparam int B_LOCK_TIMEOUT_FLAG = 0;
  localparam int B_VALID = 4;
  localparam int TO_W = 24;

  // Reset values and limits
  localparam logic [3*PRIO_W-1:0] PRIO_RST = 12'h321;
  localparam logic [RANGE_W-1:0] RANGE_MIN = 10'h001;
  localparam logic [RANGE_W-1:0] RANGE_MAX = 10'h3E8;
  localparam logic [RANGE_W-1:0] RANGE_RST = 10'h3E8;
  localparam logic [TO_W-1:0] TIMEOUT_RST = 24'h000000;
  // Frequency report LSB is 0.001 ppb
  localparam logic [FW-1:0] FREQ_LSB_PER_PPM = 40'h00000F4240;

  typedef enum logic [1:0] {
    DPS_REF_A = 2'h0,
    DPS_REF_B = 2'h1,
    DPS_REF_C = 2'h2
  } dps_ref_e;

  typedef enum logic [1:0] {
    DPS_MODE_AUTO = 2'h0,
    DPS_MODE_FORCE_OPEN = 2'h1,
    DPS_MODE_NCO = 2'h2
  } dps_mode_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [AW-1:0] adr;
    logic [31:0] dat;
  } dps_wb_req_s;

  typedef struct packed {
    logic [NREF-1:0] ref_valid;
    logic phase_locked;
    logic signed [FW-1:0] freq_offset;
    logic [31:0] phase;
  } dps_loop_in_s;

  typedef struct packed {
    logic [1:0] selected_ref;
    logic loop_closed;
    logic digital_keep;
    logic nco_active;
    logic [FW-1:0] nco_word;
  } dps_loop_out_s;
endpackage

// ### verilog/dps_pin_sync.sv
// Switch pin selection and two-stage synchroniser
`timescale 1ns/1ps
module dps_pin_sync #(
  parameter int GPIO_N = dps_pkg::GPIO_N
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [GPIO_N-1:0] gpio_in,
  input wire logic [$clog2(GPIO_N)-1:0] switch_pin_sel,
  output logic level
);
  typedef struct packed {
    logic meta;
    logic sync;
  } dps_sync_s;

  dps_sync_s st_ff;
  dps_sync_s nxt_st;

  always_comb begin
    nxt_st.meta = gpio_in[switch_pin_sel];
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.sync;
endmodule

// ### verilog/dps_ref_pick.sv
// Highest-priority valid reference finder
`timescale 1ns/1ps
module dps_ref_pick #(
  parameter int NREF = dps_pkg::NREF,
  parameter int PRIO_W = dps_pkg::PRIO_W
) (
  input wire logic [NREF*PRIO_W-1:0] prio,
  input wire logic [NREF-1:0] valid,
  output logic [1:0] top,
  output logic any
);
  logic [PRIO_W-1:0] best;

  // Lowest nonzero value wins; ties go to the lower index
  always_comb begin
    top = 2'h0;
    any = 1'b0;
    best = '1;
    for (int i = 0; i < NREF; i++) begin
      if (valid[i] && prio[i*PRIO_W +: PRIO_W] != '0 &&
          (!any || prio[i*PRIO_W +: PRIO_W] < best)) begin
        best = prio[i*PRIO_W +: PRIO_W];
        top = 2'(i);
        any = 1'b1;
      end
    end
  end
endmodule

// ### verif/dps_ctrl_chk.sv
// Port-level checker of the loop control block
`timescale 1ns/1ps
module dps_ctrl_chk #(
  parameter int GPIO_N = dps_pkg::GPIO_N,
  parameter logic [dps_pkg::FW-1:0] NCO_NOMINAL = 40'h8000000000
) (
  input wire logic clk,
  input wire logic reset,
  input wire dps_pkg::dps_wb_req_s wb_req,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [GPIO_N-1:0] gpio_in,
  input wire dps_pkg::dps_loop_in_s loop_in,
  input wire dps_pkg::dps_loop_out_s loop_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_taken;
    wb_req.cyc && wb_req.stb && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_free;
    !loop_out.loop_closed && !loop_out.digital_keep && !loop_out.nco_active;
  endsequence
  AST_ACK_NEXT:
    assert property (s_taken |=> s_answer)
    else $error("ack not one cycle after request");
  AST_DAT_IDLE:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  AST_ALL_INVALID:
    assert property (loop_in.ref_valid == 3'h0 |=> !loop_out.loop_closed)
    else $error("tracking with no valid input");
  AST_TRACK_VALID:
    assert property (loop_out.loop_closed |-> $past(loop_in.ref_valid) != 3'h0)
    else $error("tracking without a valid input before");
  AST_KEEP_OPEN:
    assert property (loop_out.digital_keep |-> !loop_out.loop_closed)
    else $error("digital hold while tracking");
  AST_NCO_OPEN:
    assert property (loop_out.nco_active && $past(loop_out.nco_active)
      |-> !loop_out.loop_closed)
    else $error("oscillator mode while tracking");
  AST_FREERUN:
    assert property (s_free ##1 s_free |-> loop_out.nco_word == NCO_NOMINAL)
    else $error("freerun word not nominal");
  AST_HOLD:
    assert property (loop_out.digital_keep && $past(loop_out.digital_keep)
      |-> $stable(loop_out.nco_word))
    else $error("held word moved");
  AST_REF_LEGAL:
    assert property (loop_out.selected_ref != 2'h3)
    else $error("selected reference out of range");
endmodule

// ### verif/dps_far_model.sv
// Model of the reference clocks, their monitors and the select pins
`timescale 1ns/1ps
module dps_far_model (
  input wire logic [2:0] cmd_valid,
  input wire logic cmd_locked,
  input wire logic signed [39:0] cmd_freq,
  input wire logic [31:0] cmd_phase,
  input wire logic [3:0] cmd_pins,
  input wire logic [1:0] sel_ref,
  output logic [3:0] gpio_in,
  output dps_pkg::dps_loop_in_s loop_in
);
  // A dead reference can never be phase locked
  assign loop_in.phase_locked = cmd_locked && sel_ref < 2'h3
    && cmd_valid[sel_ref];
  assign loop_in.ref_valid = cmd_valid;
  assign loop_in.freq_offset = cmd_freq;
  assign loop_in.phase = cmd_phase;
  assign gpio_in = cmd_pins;
endmodule

// ### verif/dps_ctrl_tb_top.sv
// Register-level testbench of the loop control block
`timescale 1ns/1ps
module dps_ctrl_tb_top;
  localparam logic [39:0] NOM = 40'h8000000000;
  logic clk = 1'b0;
  logic reset = 1'b1;
  dps_pkg::dps_wb_req_s req = '0;
  logic [31:0] rdat;
  logic ack;
  logic [3:0] gpio;
  dps_pkg::dps_loop_in_s lin;
  dps_pkg::dps_loop_out_s lout;
  logic [2:0] vld = 3'h0;
  logic lck = 1'b0;
  logic signed [39:0] frq = 40'h0;
  logic [31:0] phs = 32'h0;
  logic [3:0] pins = 4'h0;
  logic [39:0] w;
  logic [63:0] t;
  logic [31:0] q;
  int error_cnt = 0;
  int total_checks = 0;
  int n;
  always #50 clk = ~clk;
  dps_far_model dps_far_model_i (.cmd_valid(vld), .cmd_locked(lck),
    .cmd_freq(frq), .cmd_phase(phs), .cmd_pins(pins),
    .sel_ref(lout.selected_ref), .gpio_in(gpio), .loop_in(lin));
  dps_ctrl #(.NCO_NOMINAL(NOM)) dps_ctrl_i (.clk(clk), .reset(reset),
    .wb_req(req), .wb_dat_o(rdat), .wb_ack_o(ack), .gpio_in(gpio),
    .loop_in(lin), .loop_out(lout));
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] s,
                     input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
    int k;
    @(posedge clk);
    req <= '{cyc:1'b1, stb:1'b1, we:we, sel:4'hF, adr:a, dat:d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    req <= '0;
    if (k >= 20) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("adr %h", a), q & m, e);
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    // Reset values, nominal word, unmapped place
    rd(8'h04, 32'h00000FFF, 32'h00000321);
    rd(8'h10, 32'h03FF0033, 32'h03E80000);
    rd(8'h14, 32'h00000007, 32'h00000002);
    rd(8'h38, 32'hFFFFFFFF, 32'h00000000);
    rd(8'h3C, 32'h000000FF, 32'h00000080);
    chk("word", lout.nco_word, NOM);
    wr(8'hFC, 32'hFFFFFFFF);
    rd(8'hFC, 32'hFFFFFFFF, 32'h00000000);
    // Automatic selection
    vld <= 3'h7;
    lck <= 1'b1;
    settle();
    rd(8'h0C, 32'h00000033, 32'h00000000);
    rd(8'h14, 32'h00000003, 32'h00000001);
    chk("closed", lout.loop_closed, 1'b1);
    wr(8'h04, 32'h00000320);
    settle();
    rd(8'h0C, 32'h00000033, 32'h00000011);
    // Pin-driven switching on pin 2
    wr(8'h04, 32'h00000321);
    wr(8'h08, 32'h00000002);
    wr(8'h00, 32'h00000003);
    pins <= 4'h4;
    vld <= 3'h2;
    settle();
    rd(8'h0C, 32'h00000033, 32'h00000010);
    pins <= 4'hB;
    settle();
    rd(8'h0C, 32'h00000033, 32'h00000011);
    chk("sel", lout.selected_ref, 2'h1);
    wr(8'h04, 32'h00000320);
    pins <= 4'h4;
    settle();
    rd(8'h0C, 32'h00000033, 32'h00000012);
    wr(8'h04, 32'h00000321);
    vld <= 3'h7;
    wr(8'h00, 32'h00000000);
    settle();
    rd(8'h0C, 32'h00000033, 32'h00000000);
    // Open loop, hold, return, forced open
    vld <= 3'h0;
    settle();
    rd(8'h14, 32'h00000005, 32'h00000000);
    chk("word", lout.nco_word, NOM);
    wr(8'h10, 32'h03E80010);
    settle();
    rd(8'h14, 32'h00000004, 32'h00000004);
    vld <= 3'h7;
    settle();
    rd(8'h14, 32'h00000001, 32'h00000001);
    wr(8'h10, 32'h03E80001);
    settle();
    rd(8'h14, 32'h00000001, 32'h00000000);
    // Range clamp, range flag, frequency as loss of lock
    wr(8'h10, 32'h00000000);
    rd(8'h10, 32'h03FF0000, 32'h00010000);
    wr(8'h10, 32'h03FF0000);
    rd(8'h10, 32'h03FF0000, 32'h03E80000);
    wr(8'h10, 32'h00010020);
    frq <= 40'h00000F4240;
    settle();
    rd(8'h18, 32'h00000001, 32'h00000001);
    rd(8'h14, 32'h00000002, 32'h00000002);
    frq <= 40'h00000F423F;
    settle();
    rd(8'h18, 32'h00000001, 32'h00000000);
    rd(8'h14, 32'h00000002, 32'h00000000);
    // Reports
    wr(8'h10, 32'h03E80000);
    frq <= 40'h123456789A;
    phs <= 32'h1234ABCD;
    settle();
    rd(8'h24, 32'hFFFFFFFF, 32'h3456789A);
    rd(8'h28, 32'h000000FF, 32'h00000012);
    rd(8'h2C, 32'hFFFFFFFF, 32'h1234ABCD);
    frq <= 40'h0;
    // Lock timeout of ten cycles on input A
    wr(8'h20, 32'h0000000A);
    lck <= 1'b0;
    n = 0;
    while (lout.selected_ref !== 2'h1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    lck <= 1'b1;
    chk("timeout", n >= 10 && n <= 16, 1'b1);
    if (n >= 40) begin
      tally_and_finish();
    end
    rd(8'h1C, 32'h00000077, 32'h00000061);
    wr(8'h20, 32'h00000000);
    wr(8'h1C, 32'h00000001);
    rd(8'h1C, 32'h00000077, 32'h00000070);
    // Oscillator mode with a word 100 ppm above nominal
    t = (64'(NOM) * 64'h64 + 64'h7A120) / 64'hF4240;
    w = NOM + t[39:0];
    wr(8'h10, 32'h03E80002);
    wr(8'h34, {24'h0, w[39:32]});
    wr(8'h30, w[31:0]);
    settle();
    chk("nco on", lout.nco_active, 1'b1);
    chk("nco word", lout.nco_word, w);
    rd(8'h30, 32'hFFFFFFFF, w[31:0]);
    rd(8'h34, 32'h000000FF, {24'h0, w[39:32]});
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
bind dps_ctrl dps_ctrl_chk #(.GPIO_N(GPIO_N), .NCO_NOMINAL(NCO_NOMINAL))
  dps_ctrl_chk_i (.clk(clk), .reset(reset), .wb_req(wb_req),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gpio_in(gpio_in),
  .loop_in(loop_in), .loop_out(loop_out));
